// [pmt_pkg.sv]
`default_nettype none
package pmt_pkg;
   // -----------------------------------------
   // native network opcodes
   // -----------------------------------------
   localparam logic [7:0] NAT_PRI_RD    = 8'h20;
   localparam logic [7:0] NAT_NP_RD     = 8'h00;
   localparam logic [7:0] NAT_RAND_RD   = 8'h04;
   localparam logic [7:0] NAT_PRI_WR    = 8'h1E;
   localparam logic [7:0] NAT_NP_WR     = 8'h02;
   localparam logic [7:0] NAT_PRINT     = 8'h22;
   localparam logic [7:0] NAT_PRINT_RPL = 8'h92;
   // -----------------------------------------
   // modbus function codes
   // -----------------------------------------
   localparam logic [7:0] MB_RD_COIL  = 8'h01;
   localparam logic [7:0] MB_RD_INP   = 8'h02;
   localparam logic [7:0] MB_RD_HOLD  = 8'h03;
   localparam logic [7:0] MB_RD_IREG  = 8'h04;
   localparam logic [7:0] MB_WR_COIL  = 8'h05;
   localparam logic [7:0] MB_WR_REG   = 8'h06;
   localparam logic [7:0] MB_WR_COILS = 8'h0F;
   localparam logic [7:0] MB_WR_REGS  = 8'h10;
   localparam logic [7:0] MB_ENCAP    = 8'h11;
   localparam logic [7:0] MB_MASK_WR  = 8'h16;
   localparam logic [7:0] MB_RAND_RD  = 8'h64;
   // -----------------------------------------
   // markers and field values
   // -----------------------------------------
   localparam logic [7:0]  PRM_QUERY = 8'h01;
   localparam logic [7:0]  PRM_REPLY = 8'h02;
   localparam logic [7:0]  SR_COIL   = 8'h03;
   localparam logic [7:0]  SR_INPUT  = 8'h05;
   localparam logic [7:0]  TN_HIGH   = 8'h00;
   localparam logic [15:0] ENCAP_SR  = 16'hBAD5;
   localparam logic [7:0]  MB_ADR_TX = 8'h00;
   localparam logic [15:0] MASK_ALL  = 16'hFFFF;
   localparam logic [15:0] ONE16     = 16'h0001;
   localparam logic [15:0] COIL_MAX  = 16'h0010;
   localparam logic        DIR_TO_MB = 1'b0;
   // -----------------------------------------
   // types
   // -----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XLAT = 3'b010,
      ST_SEND = 3'b100
   } pmt_state_t;

   typedef struct packed {
      logic        dir;
      logic        reply;
      logic [7:0]  code;
      logic [15:0] start;
      logic [15:0] count;
      logic [15:0] mask;
      logic [7:0]  prm_cnt;
      logic [7:0]  prm;
   } pmt_msg_in_t;

   typedef struct packed {
      logic        to_mb;
      logic [7:0]  code;
      logic [15:0] status;
      logic [15:0] start;
      logic [15:0] count;
      logic [15:0] mask;
      logic        prm_vld;
      logic [7:0]  prm;
      logic [7:0]  mb_adr;
      logic        err;
   } pmt_msg_out_t;
endpackage
`default_nettype wire

// [pmt_translator.sv]
// Contract
// - native reads 0x20 and 0x00 become modbus function 3
// - native priority write 0x1E becomes modbus function 16
// - single-register write with contiguous partial mask becomes function 22
// - other native commands, except full-mask write 0x02 (function 16), ride function 17 with parameter 0x01
// - replies to encapsulated native queries ride function 17, parameter 0x02
// - function 17 carrying parameters is an encapsulated native message
// - read coils becomes priority read, status 0xMN03
// - read inputs becomes priority read, status 0xMN05
// - functions 3 and 4 become non-priority read, transnum 3 or 4
// - force single coil becomes write, transnum 5, one mask bit
// - preset single register becomes write, transnum 6
// - force coils in one register, count below 16, transnum 0x0f
// - force coils with count one may map as single coil
// - write multiple registers becomes write, transnum 0x10
// - masked write becomes write, transnum 0x10, requested mask
// - random read 100 becomes native random read 0x04
// - other modbus requests ride print 0x22, status 0xBAD5
// - replies to those ride print reply 0x92, status 0xBAD5
// - encapsulated modbus address byte sent zero, ignored on receive
// - modbus target type translates only 3, 16, 22 and 100
// - encapsulated native message at modbus port gets error reply
`default_nettype none
module pmt_translator #(
   parameter int MASK_W = 16
) (
   input  wire logic                 core_clk_in,
   input  wire logic                 nrst_in,
   input  wire logic                 cfg_tgt_mb_in,
   input  wire logic                 in_valid_in,
   input  wire pmt_pkg::pmt_msg_in_t in_msg_in,
   output logic                      in_ready_out,
   output logic                      out_valid_out,
   input  wire logic                 out_ready_in,
   output pmt_pkg::pmt_msg_out_t     out_msg_out
);

   // -----------------------------------------
   // parameter check
   // -----------------------------------------
   if (MASK_W != 16) begin : g_chk
      $error("pmt_translator: MASK_W must be 16");
   end

   pmt_pkg::pmt_state_t   state_reg;
   pmt_pkg::pmt_state_t   state_next;
   pmt_pkg::pmt_msg_in_t  h_reg;
   logic                  tgt_reg;
   logic                  in_ready_reg;
   pmt_pkg::pmt_msg_out_t res_reg;
   pmt_pkg::pmt_msg_out_t res_next;
   pmt_pkg::pmt_msg_out_t out_reg;
   pmt_pkg::pmt_msg_out_t out_next;
   pmt_pkg::pmt_msg_out_t skid_reg;
   pmt_pkg::pmt_msg_out_t skid_next;
   logic                  out_v_reg;
   logic                  out_v_next;
   logic                  skid_v_reg;
   logic                  skid_v_next;

   // -----------------------------------------
   // handshake and state
   // -----------------------------------------
   wire accept   = in_valid_in && in_ready_reg;
   wire in_xlat  = state_reg == pmt_pkg::ST_XLAT;
   wire push     = (state_reg == pmt_pkg::ST_SEND) && !skid_v_reg;
   wire pop      = out_v_reg && out_ready_in;
   wire take_out = !out_v_reg || pop;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pmt_pkg::ST_IDLE: begin
            if (accept) state_next = pmt_pkg::ST_XLAT;
         end
         pmt_pkg::ST_XLAT: begin
            state_next = pmt_pkg::ST_SEND;
         end
         pmt_pkg::ST_SEND: begin
            if (push) state_next = pmt_pkg::ST_IDLE;
         end
         default: begin
            state_next = pmt_pkg::ST_IDLE;
         end
      endcase
   end

   // -----------------------------------------
   // native to modbus decode
   // -----------------------------------------
   wire to_mb = h_reg.dir == pmt_pkg::DIR_TO_MB;
   wire [7:0]  c  = h_reg.code;
   wire [15:0] mk = h_reg.mask;
   wire [15:0] lowbit = mk & (~mk + pmt_pkg::ONE16);
   wire n_contig = (mk != '0) && (mk != pmt_pkg::MASK_ALL)
                   && (((mk + lowbit) & mk) == '0);
   wire n_read = (c == pmt_pkg::NAT_PRI_RD) || (c == pmt_pkg::NAT_NP_RD);
   wire n_pwr = c == pmt_pkg::NAT_PRI_WR;
   wire n_full = (c == pmt_pkg::NAT_NP_WR) && (mk == pmt_pkg::MASK_ALL);
   wire n_mskd = (c == pmt_pkg::NAT_NP_WR) && n_contig
                 && (h_reg.count == pmt_pkg::ONE16);
   wire n_xl = n_read || n_pwr || n_full || n_mskd;
   wire [7:0] n_fn = n_read ? pmt_pkg::MB_RD_HOLD :
                     n_mskd ? pmt_pkg::MB_MASK_WR :
                     (n_pwr || n_full) ? pmt_pkg::MB_WR_REGS :
                     pmt_pkg::MB_ENCAP;
   wire [7:0] n_prm = h_reg.reply ? pmt_pkg::PRM_REPLY
                                  : pmt_pkg::PRM_QUERY;

   // -----------------------------------------
   // modbus to native decode
   // -----------------------------------------
   wire [3:0] bitp = h_reg.start[3:0];
   wire [3:0] cnt4 = h_reg.count[3:0];
   wire m_enc = (c == pmt_pkg::MB_ENCAP) && (h_reg.prm_cnt != '0);
   wire f1  = c == pmt_pkg::MB_RD_COIL;
   wire f2  = c == pmt_pkg::MB_RD_INP;
   wire f3  = c == pmt_pkg::MB_RD_HOLD;
   wire f4  = c == pmt_pkg::MB_RD_IREG;
   wire f5  = c == pmt_pkg::MB_WR_COIL;
   wire f6  = c == pmt_pkg::MB_WR_REG;
   wire f15 = c == pmt_pkg::MB_WR_COILS;
   wire f16 = c == pmt_pkg::MB_WR_REGS;
   wire f22 = c == pmt_pkg::MB_MASK_WR;
   wire f100 = c == pmt_pkg::MB_RAND_RD;
   wire [16:0] c_end = {13'h0000, bitp} + {1'b0, h_reg.count};
   wire fit = (h_reg.count != '0) && (h_reg.count < pmt_pkg::COIL_MAX)
              && (c_end <= {1'b0, pmt_pkg::COIL_MAX});
   wire [31:0] span  = (32'h0000_0001 << cnt4) - 32'h0000_0001;
   wire [31:0] cmask = span << bitp;
   wire f15s = f15 && (h_reg.count == pmt_pkg::ONE16);
   wire m_base = f3 || f16 || f22 || f100;
   wire m_more = f1 || f2 || f4 || f5 || f6 || (f15 && fit);
   wire m_xl = m_base || (!tgt_reg && m_more);
   wire m_pread = f1 || f2;
   wire m_npread = f3 || f4;
   wire [7:0] m_op = !m_xl ? (h_reg.reply ? pmt_pkg::NAT_PRINT_RPL
                                          : pmt_pkg::NAT_PRINT) :
                     m_pread ? pmt_pkg::NAT_PRI_RD :
                     m_npread ? pmt_pkg::NAT_NP_RD :
                     f100 ? pmt_pkg::NAT_RAND_RD :
                     pmt_pkg::NAT_NP_WR;
   wire [15:0] sr_bits = {bitp, cnt4,
                          f1 ? pmt_pkg::SR_COIL : pmt_pkg::SR_INPUT};
   wire [7:0] tn = (f22 || f16) ? pmt_pkg::MB_WR_REGS :
                   f15s ? pmt_pkg::MB_WR_COIL : c;
   wire [15:0] m_sr = !m_xl ? pmt_pkg::ENCAP_SR :
                      m_pread ? sr_bits : {pmt_pkg::TN_HIGH, tn};
   wire [15:0] sbit = pmt_pkg::ONE16 << bitp;
   wire [15:0] m_mask = !m_xl ? pmt_pkg::MASK_ALL :
                        (f5 || f15s) ? sbit :
                        f15 ? cmask[15:0] :
                        f22 ? mk : pmt_pkg::MASK_ALL;

   // -----------------------------------------
   // result assembly
   // -----------------------------------------
   always_comb begin
      res_next = res_reg;
      res_next.start = h_reg.start;
      res_next.count = h_reg.count;
      res_next.mb_adr = pmt_pkg::MB_ADR_TX;
      if (to_mb) begin
         res_next.to_mb   = 1'b1;
         res_next.code    = n_fn;
         res_next.status  = '0;
         res_next.mask    = mk;
         res_next.prm_vld = !n_xl;
         res_next.prm     = n_xl ? '0 : n_prm;
         res_next.err     = 1'b0;
      end else if (m_enc) begin
         res_next.to_mb   = 1'b1;
         res_next.code    = pmt_pkg::MB_ENCAP;
         res_next.status  = '0;
         res_next.mask    = pmt_pkg::MASK_ALL;
         res_next.prm_vld = 1'b1;
         res_next.prm     = pmt_pkg::PRM_REPLY;
         res_next.err     = 1'b1;
      end else begin
         res_next.to_mb   = 1'b0;
         res_next.code    = m_op;
         res_next.status  = m_sr;
         res_next.mask    = m_mask;
         res_next.prm_vld = 1'b0;
         res_next.prm     = '0;
         res_next.err     = 1'b0;
      end
   end

   // -----------------------------------------
   // two-entry output buffer
   // -----------------------------------------
   assign out_v_next  = skid_v_reg || push || (out_v_reg && !pop);
   assign out_next    = !take_out ? out_reg :
                        skid_v_reg ? skid_reg : res_reg;
   assign skid_v_next = skid_v_reg ? !pop : (push && !take_out);
   assign skid_next   = (push && !take_out) ? res_reg : skid_reg;

   // -----------------------------------------
   // registers
   // -----------------------------------------
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg    <= pmt_pkg::ST_IDLE;
         in_ready_reg <= 1'b1;
         h_reg        <= '0;
         tgt_reg      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         in_ready_reg <= state_next == pmt_pkg::ST_IDLE;
         if (accept) h_reg <= in_msg_in;
         if (accept) tgt_reg <= cfg_tgt_mb_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         res_reg    <= '0;
         out_reg    <= '0;
         skid_reg   <= '0;
         out_v_reg  <= 1'b0;
         skid_v_reg <= 1'b0;
      end else begin
         if (in_xlat) res_reg <= res_next;
         out_reg    <= out_next;
         skid_reg   <= skid_next;
         out_v_reg  <= out_v_next;
         skid_v_reg <= skid_v_next;
      end
   end

   assign in_ready_out  = in_ready_reg;
   assign out_valid_out = out_v_reg;
   assign out_msg_out   = out_reg;

   // -----------------------------------------
   // assertions
   // -----------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);

   AST_NAT_READ: assert property (
      in_xlat && to_mb && n_read
      |=> res_reg.code == pmt_pkg::MB_RD_HOLD && !res_reg.prm_vld)
      else $error("native read not mapped to function 3");

   AST_PRI_WRITE: assert property (
      in_xlat && to_mb && n_pwr
      |=> res_reg.code == pmt_pkg::MB_WR_REGS)
      else $error("priority write not mapped to function 16");

   AST_FULL_MASK: assert property (
      in_xlat && to_mb && n_full
      |=> res_reg.code == pmt_pkg::MB_WR_REGS)
      else $error("full mask write not mapped to function 16");

   AST_MASKED: assert property (
      in_xlat && to_mb && (c == pmt_pkg::NAT_NP_WR)
      && (h_reg.count == pmt_pkg::ONE16) && (mk == 16'h0FF0)
      |=> res_reg.code == pmt_pkg::MB_MASK_WR)
      else $error("partial mask write not mapped to function 22");

   AST_ENCAP_NAT: assert property (
      in_xlat && to_mb && !n_xl && !h_reg.reply
      |=> res_reg.code == pmt_pkg::MB_ENCAP
          && res_reg.prm == pmt_pkg::PRM_QUERY && res_reg.prm_vld)
      else $error("native command not encapsulated");

   AST_REPLY_ENC: assert property (
      in_xlat && to_mb && !n_xl && h_reg.reply
      |=> res_reg.code == pmt_pkg::MB_ENCAP
          && res_reg.prm == pmt_pkg::PRM_REPLY && res_reg.prm_vld)
      else $error("native reply not encapsulated with reply marker");

   AST_INPUT_READ: assert property (
      in_xlat && !to_mb && f2 && !tgt_reg
      |=> res_reg.code == pmt_pkg::NAT_PRI_RD
          && res_reg.status[7:0] == 8'h05)
      else $error("input read status address wrong");

   AST_REG_READ: assert property (
      in_xlat && !to_mb && f4 && !tgt_reg
      |=> res_reg.code == pmt_pkg::NAT_NP_RD
          && res_reg.status == 16'h0004)
      else $error("input register read transaction number wrong");

   AST_ONE_COIL: assert property (
      in_xlat && !to_mb && f5 && !tgt_reg
      |=> res_reg.code == pmt_pkg::NAT_NP_WR
          && res_reg.status == 16'h0005 && $onehot(res_reg.mask))
      else $error("single coil write not one mask bit");

   AST_RAND_READ: assert property (
      in_xlat && !to_mb && f100
      |=> res_reg.code == pmt_pkg::NAT_RAND_RD)
      else $error("random read not mapped to native random read");

   AST_PRINT_RPL: assert property (
      in_xlat && !to_mb && !m_xl && !m_enc && h_reg.reply
      |=> res_reg.code == pmt_pkg::NAT_PRINT_RPL
          && res_reg.status == 16'hBAD5)
      else $error("untranslatable reply not carried in print reply");

   AST_COIL_READ: assert property (
      in_xlat && !to_mb && f1 && !tgt_reg && !m_enc
      |=> res_reg.code == pmt_pkg::NAT_PRI_RD
          && res_reg.status == {$past(bitp), $past(cnt4), 8'h03})
      else $error("coil read status address wrong");

   AST_PRINT: assert property (
      in_xlat && !to_mb && !m_xl && !m_enc && !h_reg.reply
      |=> res_reg.code == pmt_pkg::NAT_PRINT
          && res_reg.status == 16'hBAD5 && res_reg.mb_adr == 8'h00)
      else $error("untranslatable request not carried in print");

   AST_TARGET_MB: assert property (
      in_xlat && !to_mb && tgt_reg && f6
      |=> res_reg.status == 16'hBAD5)
      else $error("modbus target translated function 6");

   AST_ENC_ERR: assert property (
      in_xlat && !to_mb && m_enc
      |=> res_reg.err && res_reg.code == pmt_pkg::MB_ENCAP)
      else $error("encapsulated native message not refused");

   AST_ONE_AT_TIME: assert property (
      accept |=> !in_ready_out ##1 !in_ready_out)
      else $error("second message taken too early");

   AST_NO_LOSS: assert property (
      skid_v_reg && !pop |=> out_valid_out && skid_v_reg)
      else $error("buffered word lost under stall");

endmodule // pmt_translator
`default_nettype wire

// [pmt_sink.sv]
`default_nettype none
module pmt_sink (
   input  wire logic                  core_clk_in,
   input  wire logic                  nrst_in,
   input  wire logic [1:0]            mode_in,
   input  wire logic                  out_valid_in,
   input  wire pmt_pkg::pmt_msg_out_t out_msg_in,
   output logic                       out_ready_out,
   output logic                       got_out,
   output pmt_pkg::pmt_msg_out_t      got_msg_out,
   output logic                       got_encap_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] lfsr_reg;
   assign got_encap_out = (got_msg_out.code == 8'h11) && got_msg_out.prm_vld;
   // -------------------------------------
   // receiver: prompt, random or stalled
   // -------------------------------------
   // address byte never looked at
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lfsr_reg <= 16'h5A5A;
         out_ready_out <= 1'b0;
         got_out <= 1'b0;
         got_msg_out <= '0;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13]};
         out_ready_out <= (mode_in == 2'd0)
                          | ((mode_in == 2'd1) & lfsr_reg[0]);
         got_out <= out_valid_in & out_ready_out;
         got_msg_out <= out_msg_in;
      end
   end
endmodule // pmt_sink
`default_nettype wire

// [plc_message_translator_bench.sv]
`default_nettype none
module plc_message_translator_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      pmt_pkg::pmt_msg_out_t m;
      logic                  cs;
      logic                  cm;
   } pmt_exp_t;
   logic                  core_clk_in = 1'b0;
   logic                  nrst_in = 1'b0;
   logic                  cfg = 1'b0;
   logic                  in_valid = 1'b0;
   pmt_pkg::pmt_msg_in_t  in_msg = '0;
   logic [1:0]            mode = 2'd0;
   logic                  in_ready_out;
   logic                  out_valid_out;
   logic                  out_ready;
   pmt_pkg::pmt_msg_out_t out_msg;
   logic                  got;
   logic                  got_enc;
   pmt_pkg::pmt_msg_out_t got_msg;
   logic [15:0]           lfsr = 16'hC8F4;
   int                    n_errors = 0;
   int                    comparisons = 0;
   int                    cyc = 0;
   pmt_exp_t              exq[$];
   logic [7:0]            ct[15] = '{8'h20, 8'h00, 8'h1E, 8'h02, 8'h22,
      8'h01, 8'h02, 8'h03, 8'h05, 8'h0F, 8'h10, 8'h16, 8'h64, 8'h11, 8'h2B};
   logic [7:0]            c1[7] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h10,
      8'h16, 8'h64};
   always #4 core_clk_in = ~core_clk_in;
   pmt_translator DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .cfg_tgt_mb_in(cfg), .in_valid_in(in_valid), .in_msg_in(in_msg),
      .in_ready_out(in_ready_out), .out_valid_out(out_valid_out),
      .out_ready_in(out_ready), .out_msg_out(out_msg));
   pmt_sink u_sink (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
      .mode_in(mode), .out_valid_in(out_valid_out), .out_msg_in(out_msg),
      .out_ready_out(out_ready), .got_out(got), .got_msg_out(got_msg),
      .got_encap_out(got_enc));
   // -------------------------------------
   // helpers
   // -------------------------------------
   task automatic end_sim;
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string s);
      comparisons++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, s);
      end
   endtask
   function automatic logic contig(input logic [15:0] m);
      logic [15:0] x;
      x = m | (m - 16'h0001);
      return (m != 16'h0000) && ((x & (x + 16'h0001)) == 16'h0000);
   endfunction
   function automatic pmt_exp_t exp_of(input pmt_pkg::pmt_msg_in_t i,
                                       input logic c);
      pmt_exp_t    e;
      logic [15:0] sh;
      logic        enc;
      logic        mbok;
      e = '0;
      enc = 1'b0;
      sh = 16'h0001 << i.start[3:0];
      mbok = i.code inside {8'h03, 8'h10, 8'h16, 8'h64};
      e.m.to_mb = !i.dir;
      if (!i.dir) begin
         if (i.code == 8'h20 || i.code == 8'h00) e.m.code = 8'h03;
         else if (i.code == 8'h1E || (i.code == 8'h02 && i.mask == 16'hFFFF))
            e.m.code = 8'h10;
         else if (i.code == 8'h02 && i.count == 16'h0001 && contig(i.mask))
            {e.m.code, e.m.mask, e.cm} = {8'h16, i.mask, 1'b1};
         else
            {e.m.code, e.m.prm_vld, e.m.prm} =
               {8'h11, 1'b1, i.reply ? 8'h02 : 8'h01};
      end else if (i.code == 8'h11 && i.prm_cnt != 8'h00)
         {e.m.to_mb, e.m.code, e.m.prm_vld, e.m.prm, e.m.err} =
            {1'b1, 8'h11, 1'b1, 8'h02, 1'b1};
      else if (c && !mbok) enc = 1'b1;
      else begin
         e.cs = 1'b1;
         e.m.code = 8'h02;
         case (i.code)
            8'h01, 8'h02: begin
               e.m.code = 8'h20;
               e.m.status = {i.start[3:0], i.count[3:0],
                             (i.code == 8'h01) ? 8'h03 : 8'h05};
            end
            8'h03, 8'h04: {e.m.code, e.m.status} = {8'h00, 8'h00, i.code};
            8'h05: {e.m.status, e.m.mask, e.cm} = {16'h0005, sh, 1'b1};
            8'h06: e.m.status = 16'h0006;
            8'h0F: begin
               e.cm = 1'b1;
               if (i.count == 16'h0001)
                  {e.m.status, e.m.mask} = {16'h0005, sh};
               else if (i.count < 16'h0010 && i.count != 16'h0000 &&
                        {12'h000, i.start[3:0]} + i.count <= 16'h0010)
                  {e.m.status, e.m.mask} = {16'h000F,
                     ((16'h0001 << i.count) - 16'h0001) << i.start[3:0]};
               else enc = 1'b1;
            end
            8'h10: e.m.status = 16'h0010;
            8'h16: {e.m.status, e.m.mask, e.cm} = {16'h0010, i.mask, 1'b1};
            8'h64: {e.m.code, e.cs} = {8'h04, 1'b0};
            default: enc = 1'b1;
         endcase
      end
      if (enc)
         {e.m.code, e.m.status, e.m.mask, e.cs, e.cm} = {i.reply ? 8'h92 :
            8'h22, 16'hBAD5, 16'hFFFF, 2'b11};
      return e;
   endfunction
   function automatic pmt_pkg::pmt_msg_in_t mk(input logic d, input logic r,
      input logic [7:0] c, input logic [15:0] s, input logic [15:0] n,
      input logic [15:0] m, input logic p);
      return {d, r, c, s, n, m, {7'h00, p}, 8'h01};
   endfunction
   function automatic pmt_pkg::pmt_msg_in_t rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return mk(lfsr[0], lfsr[1], ct[lfsr[15:8] % 15], {lfsr[7:0], lfsr[15:8]},
         lfsr[4] ? 16'h0001 : {12'h000, lfsr[11:8]},
         lfsr[5] ? 16'hFFFF : {lfsr[3:0], lfsr[15:4]}, lfsr[6] & lfsr[2]);
   endfunction
   task automatic send(input pmt_pkg::pmt_msg_in_t m, input logic c);
      @(negedge core_clk_in);
      {in_msg, cfg, in_valid} = {m, c, 1'b1};
      exq.push_back(exp_of(m, c));
      while (in_ready_out !== 1'b1) @(negedge core_clk_in);
      @(negedge core_clk_in);
      in_valid = 1'b0;
      chk(in_ready_out === 1'b0, "ready right after take");
   endtask
   // -------------------------------------
   // output monitor
   // -------------------------------------
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("MISMATCH %0t timeout", $time);
         end_sim();
      end
      if (got === 1'b1) begin
         if (exq.size() == 0) chk(1'b0, "unexpected output");
         else begin
            pmt_exp_t e;
            e = exq.pop_front();
            chk(got_msg.code === e.m.code, "code");
            chk(got_msg.to_mb === e.m.to_mb, "direction");
            chk(got_msg.err === e.m.err, "error flag");
            chk(got_msg.mb_adr === 8'h00, "address byte");
            chk(!e.cs || got_msg.status === e.m.status, "status");
            chk(!e.cm || got_msg.mask === e.m.mask, "mask");
            chk(!e.m.prm_vld || {got_msg.prm_vld, got_msg.prm} ===
                {1'b1, e.m.prm}, "parameter");
            chk(got_enc === (e.m.code == 8'h11 && e.m.prm_vld), "encap");
         end
      end
   end
   // -------------------------------------
   // main sequence
   // -------------------------------------
   initial begin
      repeat (6) @(posedge core_clk_in);
      chk(in_ready_out === 1'b1 && out_valid_out === 1'b0, "reset values");
      @(negedge core_clk_in);
      nrst_in = 1'b1;
      send(mk(0, 0, 8'h20, 16'h0010, 16'h0004, 16'hFFFF, 0), 0);
      send(mk(0, 0, 8'h00, 16'h0010, 16'h0004, 16'hFFFF, 0), 0);
      send(mk(0, 0, 8'h1E, 16'h0001, 16'h0002, 16'h0000, 0), 0);
      send(mk(0, 0, 8'h02, 16'h0001, 16'h0003, 16'hFFFF, 0), 0);
      send(mk(0, 0, 8'h02, 16'h0001, 16'h0001, 16'h0FF0, 0), 0);
      send(mk(0, 0, 8'h02, 16'h0001, 16'h0001, 16'h0F0F, 0), 0);
      send(mk(0, 0, 8'h02, 16'h0001, 16'h0002, 16'h00F0, 0), 0);
      send(mk(0, 0, 8'h22, 16'h0001, 16'h0002, 16'h0000, 0), 0);
      send(mk(0, 1, 8'h22, 16'h0001, 16'h0002, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h11, 16'h0001, 16'h0002, 16'h0000, 1), 0);
      send(mk(1, 0, 8'h01, 16'h0025, 16'h0013, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h02, 16'h003F, 16'h0020, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h03, 16'h0005, 16'h0002, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h04, 16'h0005, 16'h0002, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h05, 16'h001F, 16'h0001, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h06, 16'h0007, 16'h0001, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h0F, 16'h0008, 16'h0008, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h0F, 16'h0009, 16'h0008, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h0F, 16'h0000, 16'h0010, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h0F, 16'h0003, 16'h0001, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h10, 16'h0002, 16'h0004, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h16, 16'h0002, 16'h0001, 16'h00F0, 0), 0);
      send(mk(1, 0, 8'h64, 16'h0002, 16'h0003, 16'h0000, 0), 0);
      send(mk(1, 0, 8'h2B, 16'h0002, 16'h0003, 16'h0000, 0), 0);
      send(mk(1, 1, 8'h2B, 16'h0002, 16'h0003, 16'h0000, 0), 0);
      foreach (c1[k])
         send(mk(1, 0, c1[k], 16'h0004, 16'h0002, 16'h0F00, 0), 1);
      mode = 2'd2;
      fork
         repeat (5) send(rnd(), lfsr[9]);
         begin
            repeat (60) @(negedge core_clk_in);
            chk(in_ready_out === 1'b0, "take while buffer full");
            chk(out_valid_out === 1'b1, "word held during stall");
            mode = 2'd0;
         end
      join
      mode = 2'd1;
      repeat (300) send(rnd(), lfsr[9]);
      mode = 2'd0;
      repeat (20) @(negedge core_clk_in);
      chk(exq.size() == 0, "missing outputs");
      end_sim();
   end
endmodule // plc_message_translator_bench
`default_nettype wire
